// >>> verilog/rla_pkg.sv
// Constants for the link address and internal link control header bank.
// Assumes the configuration request logic presents dword-aligned byte offsets.
package rla_pkg;

    // Configuration space offsets, byte addresses
    localparam logic [11:0] LINK_ENTRY_DEF_OFS = 12'h110;
    localparam logic [11:0] LINK_ADDR_LO_OFS = 12'h008;
    localparam logic [11:0] LINK_ADDR_HI_OFS = 12'h00C;
    localparam logic [11:0] ILC_CAP_DEF_OFS = 12'h140;
    localparam int ADDR_W = 12;
    localparam int DWORD_LSB = 2;

    // Memory-mapped layout
    localparam logic [63:0] MEM_LOW_ZERO_MASK = 64'h0000_0000_0000_0FFF;

    // Configuration layout fields
    localparam int BUS_CODE_MSB = 2;
    localparam int FUNC_LSB = 12;
    localparam int DEV_LSB = 15;
    localparam int BUS_LSB = 20;
    localparam int RSVD_LSB = 3;
    localparam int RSVD_MSB = 11;
    localparam logic [2:0] BUS_CODE_EIGHT = 3'h0;
    localparam int BUS_BITS_MAX = 8;

    // Capability header
    localparam logic [15:0] ILC_CAP_ID = 16'h0006;
    localparam logic [3:0] ILC_CAP_VER = 4'h1;
    localparam int CAP_VER_LSB = 16;
    localparam int NEXT_PTR_LSB = 20;
    localparam logic [11:0] NEXT_PTR_END = 12'h000;
    localparam logic [11:0] NEXT_PTR_MIN_EXCL = 12'h0FF;
    localparam logic [11:0] NEXT_PTR_LOW_MASK = 12'hFFC;

    // Element type codes
    localparam logic [3:0] ELEM_INTERNAL_LINK = 4'h2;

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

// >>> verilog/rla_link_addr_regs.sv
// Read-only link address and internal link control capability header bank.
// Assumes single-cycle read and write strobes from same-clock configuration logic.
`timescale 1ns/100ps

module rla_link_addr_regs #(
    parameter logic [11:0] LINK_ENTRY_OFS = rla_pkg::LINK_ENTRY_DEF_OFS,
    parameter logic [11:0] ILC_CAP_OFS = rla_pkg::ILC_CAP_DEF_OFS,
    parameter logic LINK_TYPE = 1'b0,
    parameter logic [63:0] MEM_BASE = 64'h0000_0000_FED0_0000,
    parameter logic [2:0] BUS_WIDTH_CODE = 3'h0,
    parameter logic [2:0] FUNC_NUM = 3'h0,
    parameter logic [4:0] DEV_NUM = 5'h00,
    parameter logic [7:0] BUS_NUM = 8'h00,
    parameter logic [63:0] CFG_BASE = 64'h0000_0000_0000_0000,
    parameter logic [3:0] ELEMENT_TYPE = rla_pkg::ELEM_INTERNAL_LINK,
    parameter logic [11:0] NEXT_CAP = 12'h000
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Configuration requests
    input wire logic REQ_RD,
    input wire logic REQ_WR,
    input wire logic [11:0] REQ_ADDR,
    input wire logic [31:0] REQ_WDATA,
    // Read answer
    output logic RSP_VALID,
    output logic [31:0] RSP_RDATA
);

    localparam int BUS_BITS = (BUS_WIDTH_CODE == rla_pkg::BUS_CODE_EIGHT) ?
        rla_pkg::BUS_BITS_MAX : int'(BUS_WIDTH_CODE);
    localparam logic [63:0] BUS_MASK = (64'h1 << BUS_BITS) - 64'h1;
    localparam logic [63:0] BASE_MASK = ~((64'h1 << (rla_pkg::BUS_LSB + BUS_BITS)) - 64'h1);

    // Memory layout: base with low bits forced clear
    localparam logic [63:0] MEM_VALUE = MEM_BASE & ~rla_pkg::MEM_LOW_ZERO_MASK;

    // Configuration layout; reserved 11:3 stay clear by construction
    localparam logic [63:0] CFG_VALUE =
        (CFG_BASE & BASE_MASK) |
        ((64'(BUS_NUM) & BUS_MASK) << rla_pkg::BUS_LSB) |
        (64'(DEV_NUM) << rla_pkg::DEV_LSB) |
        (64'(FUNC_NUM) << rla_pkg::FUNC_LSB) |
        64'(BUS_WIDTH_CODE);

    // Pointers into conventional space are illegal, so they end the list instead
    localparam logic NEXT_OK = (NEXT_CAP == rla_pkg::NEXT_PTR_END) ||
        (NEXT_CAP > rla_pkg::NEXT_PTR_MIN_EXCL);
    localparam logic [11:0] NEXT_VALUE = NEXT_OK ?
        (NEXT_CAP & rla_pkg::NEXT_PTR_LOW_MASK) : rla_pkg::NEXT_PTR_END;
    localparam logic [31:0] HDR_VALUE = {NEXT_VALUE, rla_pkg::ILC_CAP_VER, rla_pkg::ILC_CAP_ID};
    localparam logic CAP_ON = (ELEMENT_TYPE == rla_pkg::ELEM_INTERNAL_LINK);

    localparam logic [11:0] LO_ADDR = LINK_ENTRY_OFS + rla_pkg::LINK_ADDR_LO_OFS;
    localparam logic [11:0] HI_ADDR = LINK_ENTRY_OFS + rla_pkg::LINK_ADDR_HI_OFS;

    // Dword indexes of the three mapped words
    localparam logic [9:0] LO_DW = LO_ADDR[rla_pkg::ADDR_W-1:rla_pkg::DWORD_LSB];
    localparam logic [9:0] HI_DW = HI_ADDR[rla_pkg::ADDR_W-1:rla_pkg::DWORD_LSB];
    localparam logic [9:0] CAP_DW = ILC_CAP_OFS[rla_pkg::ADDR_W-1:rla_pkg::DWORD_LSB];

    logic [63:0] link_addr_r;
    logic [31:0] cap_hdr_r;
    logic cap_on_r;
    logic [31:0] rd_data_nxt;
    logic [9:0] req_dw;
    logic rsp_valid_r;
    logic [31:0] rsp_rdata_r;

    // Written data has nowhere to go; the bank is fixed after initialisation
    logic unused_wr;
    assign unused_wr = REQ_WR ^ (^REQ_WDATA);

    // Hardware initialisation: values load at reset and then hold
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            link_addr_r <= LINK_TYPE ? CFG_VALUE : MEM_VALUE;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            cap_hdr_r <= HDR_VALUE;
            cap_on_r <= CAP_ON;
        end
    end

    // Address decode on dword index; byte offset bits are ignored
    assign req_dw = REQ_ADDR[rla_pkg::ADDR_W-1:rla_pkg::DWORD_LSB];

    always_comb begin
        rd_data_nxt = rla_pkg::UNMAPPED_DATA;
        if (req_dw == LO_DW) begin
            rd_data_nxt = link_addr_r[31:0];
        end else if (req_dw == HI_DW) begin
            rd_data_nxt = link_addr_r[63:32];
        end else if (cap_on_r && req_dw == CAP_DW) begin
            rd_data_nxt = cap_hdr_r;
        end
    end

    // One-cycle read answer; data holds until the next read
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= rla_pkg::UNMAPPED_DATA;
        end else begin
            rsp_valid_r <= REQ_RD;
            if (REQ_RD) begin
                rsp_rdata_r <= rd_data_nxt;
            end
        end
    end

    assign RSP_VALID = rsp_valid_r;
    assign RSP_RDATA = rsp_rdata_r;

    property p_lo_read;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD && req_dw == LO_DW |=> RSP_VALID && RSP_RDATA == link_addr_r[31:0];
    endproperty
    a_lo_read: assert property (p_lo_read)
        else $error("low link address read wrong");

    property p_hi_read;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD && req_dw == HI_DW |=> RSP_VALID && RSP_RDATA == link_addr_r[63:32];
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("high link address read wrong");

    property p_unmapped;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD && req_dw != LO_DW && req_dw != HI_DW && req_dw != CAP_DW |=>
            RSP_RDATA == rla_pkg::UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_mem_select;
        @(posedge CLOCK) disable iff (SYS_RST)
        !LINK_TYPE |-> link_addr_r == MEM_VALUE;
    endproperty
    a_mem_select: assert property (p_mem_select)
        else $error("memory layout not selected");

    property p_cfg_select;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE |-> link_addr_r == CFG_VALUE;
    endproperty
    a_cfg_select: assert property (p_cfg_select)
        else $error("configuration layout not selected");

    property p_mem_layout;
        @(posedge CLOCK) disable iff (SYS_RST)
        !LINK_TYPE |-> (link_addr_r & rla_pkg::MEM_LOW_ZERO_MASK) == 64'h0 &&
            (link_addr_r | rla_pkg::MEM_LOW_ZERO_MASK) == (MEM_BASE | rla_pkg::MEM_LOW_ZERO_MASK);
    endproperty
    a_mem_layout: assert property (p_mem_layout)
        else $error("memory layout wrong");

    property p_mem_high;
        @(posedge CLOCK) disable iff (SYS_RST)
        !LINK_TYPE |-> link_addr_r[63:32] == MEM_BASE[63:32];
    endproperty
    a_mem_high: assert property (p_mem_high)
        else $error("memory base high dword wrong");

    property p_bus_code;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE |-> ((link_addr_r[rla_pkg::BUS_CODE_MSB:0] == rla_pkg::BUS_CODE_EIGHT) ?
            rla_pkg::BUS_BITS_MAX : int'(link_addr_r[rla_pkg::BUS_CODE_MSB:0])) == BUS_BITS;
    endproperty
    a_bus_code: assert property (p_bus_code)
        else $error("bus width code does not match width");

    property p_cfg_rsvd;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE |-> link_addr_r[rla_pkg::RSVD_MSB:rla_pkg::RSVD_LSB] == '0 &&
            link_addr_r[rla_pkg::BUS_CODE_MSB:0] == BUS_WIDTH_CODE;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd)
        else $error("config reserved bits set");

    property p_cfg_fd;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE |-> link_addr_r[rla_pkg::DEV_LSB-1:rla_pkg::FUNC_LSB] == FUNC_NUM &&
            link_addr_r[rla_pkg::BUS_LSB-1:rla_pkg::DEV_LSB] == DEV_NUM;
    endproperty
    a_cfg_fd: assert property (p_cfg_fd)
        else $error("function or device misplaced");

    property p_cfg_bus;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE |-> ((link_addr_r >> rla_pkg::BUS_LSB) & BUS_MASK) == (64'(BUS_NUM) & BUS_MASK)
            && (link_addr_r & BASE_MASK) == (CFG_BASE & BASE_MASK);
    endproperty
    a_cfg_bus: assert property (p_cfg_bus)
        else $error("bus or config base wrong");

    property p_cfg_base_zero;
        @(posedge CLOCK) disable iff (SYS_RST)
        LINK_TYPE && (CFG_BASE & BASE_MASK) == 64'h0 |->
            (link_addr_r & BASE_MASK) == 64'h0;
    endproperty
    a_cfg_base_zero: assert property (p_cfg_base_zero)
        else $error("default segment base not zero");

    property p_cap_hdr;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD && cap_on_r && req_dw == CAP_DW |=>
            RSP_RDATA[rla_pkg::CAP_VER_LSB-1:0] == rla_pkg::ILC_CAP_ID &&
            RSP_RDATA[rla_pkg::NEXT_PTR_LSB-1:rla_pkg::CAP_VER_LSB] == rla_pkg::ILC_CAP_VER;
    endproperty
    a_cap_hdr: assert property (p_cap_hdr)
        else $error("capability header wrong");

    property p_cap_id;
        @(posedge CLOCK) disable iff (SYS_RST)
        cap_hdr_r[rla_pkg::CAP_VER_LSB-1:0] == rla_pkg::ILC_CAP_ID;
    endproperty
    a_cap_id: assert property (p_cap_id)
        else $error("capability identifier wrong");

    property p_cap_ver;
        @(posedge CLOCK) disable iff (SYS_RST)
        cap_hdr_r[rla_pkg::NEXT_PTR_LSB-1:rla_pkg::CAP_VER_LSB] == rla_pkg::ILC_CAP_VER;
    endproperty
    a_cap_ver: assert property (p_cap_ver)
        else $error("capability version wrong");

    property p_next_ptr;
        @(posedge CLOCK) disable iff (SYS_RST)
        cap_hdr_r[31:rla_pkg::NEXT_PTR_LSB] == rla_pkg::NEXT_PTR_END ||
            cap_hdr_r[31:rla_pkg::NEXT_PTR_LSB] > rla_pkg::NEXT_PTR_MIN_EXCL;
    endproperty
    a_next_ptr: assert property (p_next_ptr)
        else $error("next pointer illegal");

    property p_next_low;
        @(posedge CLOCK) disable iff (SYS_RST)
        (cap_hdr_r[31:rla_pkg::NEXT_PTR_LSB] & ~rla_pkg::NEXT_PTR_LOW_MASK) ==
            rla_pkg::NEXT_PTR_END;
    endproperty
    a_next_low: assert property (p_next_low)
        else $error("next pointer low bits set");

    property p_cap_absent;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD && ELEMENT_TYPE != rla_pkg::ELEM_INTERNAL_LINK && req_dw == CAP_DW &&
            req_dw != LO_DW && req_dw != HI_DW |=> RSP_RDATA == rla_pkg::UNMAPPED_DATA;
    endproperty
    a_cap_absent: assert property (p_cap_absent)
        else $error("header seen off internal link");

    property p_cap_enable;
        @(posedge CLOCK) disable iff (SYS_RST)
        cap_on_r == (ELEMENT_TYPE == rla_pkg::ELEM_INTERNAL_LINK);
    endproperty
    a_cap_enable: assert property (p_cap_enable)
        else $error("capability enable does not follow element type");

    property p_write_ignored;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_WR |=> $stable(link_addr_r) && $stable(cap_hdr_r) ##1 $stable(link_addr_r);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write changed bank");

    property p_bank_stable;
        @(posedge CLOCK) disable iff (SYS_RST)
        $stable(link_addr_r) && $stable(cap_hdr_r) && $stable(cap_on_r);
    endproperty
    a_bank_stable: assert property (p_bank_stable)
        else $error("bank changed outside reset");

    property p_valid_pulse;
        @(posedge CLOCK) disable iff (SYS_RST)
        REQ_RD ##1 !REQ_RD |-> RSP_VALID ##1 !RSP_VALID;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("answer timing wrong");

    property p_no_answer;
        @(posedge CLOCK) disable iff (SYS_RST)
        !REQ_RD |=> !RSP_VALID;
    endproperty
    a_no_answer: assert property (p_no_answer)
        else $error("answer without read");

    property p_rdata_hold;
        @(posedge CLOCK) disable iff (SYS_RST)
        !REQ_RD |=> $stable(RSP_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without read");

    // Checked through reset on purpose, so no disable clause here
    property p_rst_quiet;
        @(posedge CLOCK)
        SYS_RST |=> !RSP_VALID && RSP_RDATA == rla_pkg::UNMAPPED_DATA;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("answer not cleared by reset");

endmodule

// >>> dv/rla_link_addr_regs_tb.sv
// Self-checking bench for the read-only link address and capability header bank.
// Assumes three bank instances sharing one request port, each with its own answer.
`timescale 1ns/100ps

module testbench;
    localparam logic [63:0] CB = 64'h0000_0012_3456_7FFF;
    localparam logic [63:0] MB = 64'h0000_00AB_CDEF_1FFF;
    localparam logic [7:0] BN = 8'hFD;
    localparam logic [11:0] LO = rla_pkg::LINK_ENTRY_DEF_OFS + rla_pkg::LINK_ADDR_LO_OFS;
    localparam logic [11:0] HI = rla_pkg::LINK_ENTRY_DEF_OFS + rla_pkg::LINK_ADDR_HI_OFS;
    localparam logic [11:0] CAP = rla_pkg::ILC_CAP_DEF_OFS;
    localparam logic T_CFG = 1'b1;
    localparam logic T_MEM = 1'b0;
    localparam logic [2:0] W_A = 3'h3;
    localparam logic [2:0] W_C = 3'h0;
    localparam logic [2:0] FN_A = 3'h5;
    localparam logic [2:0] FN_C = 3'h2;
    localparam logic [4:0] DV_A = 5'h1A;
    localparam logic [4:0] DV_C = 5'h07;
    localparam logic [7:0] BN_C = 8'hA5;
    localparam logic [63:0] CB_C = 64'h0000_0000_0000_0000;
    localparam logic [11:0] NX_A = 12'h203;
    localparam logic [11:0] NX_C = 12'h0FC;
    localparam logic [3:0] ET_B = 4'h1;
    // Three-bit bus field keeps only the low bits of BN; base keeps bits 31:23
    localparam logic [31:0] A_LO = {CB[31:23], BN[2:0], DV_A, FN_A, 9'h000, W_A};
    localparam logic [31:0] A_CAP = {12'h200, 4'h1, 16'h0006};
    localparam logic [31:0] B_LO = {MB[31:12], 12'h000};
    localparam logic [31:0] C_LO = {CB_C[31:28], BN_C, DV_C, FN_C, 9'h000, W_C};
    localparam logic [31:0] C_CAP = {12'h000, 4'h1, 16'h0006};
    logic clk, rst, rd_s, wr_s;
    logic [11:0] addr;
    logic [31:0] wdata, da, db, dc;
    logic va, vb, vc;
    int error_cnt, samples_checked;

    rla_link_addr_regs #(.LINK_TYPE(T_CFG), .BUS_WIDTH_CODE(W_A), .FUNC_NUM(FN_A),
        .DEV_NUM(DV_A), .BUS_NUM(BN), .CFG_BASE(CB), .NEXT_CAP(NX_A)) dut_u (
        .CLOCK(clk), .SYS_RST(rst), .REQ_RD(rd_s), .REQ_WR(wr_s), .REQ_ADDR(addr),
        .REQ_WDATA(wdata), .RSP_VALID(va), .RSP_RDATA(da));
    rla_link_addr_regs #(.LINK_TYPE(T_MEM), .MEM_BASE(MB), .ELEMENT_TYPE(ET_B)) mem_u (
        .CLOCK(clk), .SYS_RST(rst), .REQ_RD(rd_s), .REQ_WR(wr_s), .REQ_ADDR(addr),
        .REQ_WDATA(wdata), .RSP_VALID(vb), .RSP_RDATA(db));
    rla_link_addr_regs #(.LINK_TYPE(T_CFG), .BUS_WIDTH_CODE(W_C), .FUNC_NUM(FN_C),
        .DEV_NUM(DV_C), .BUS_NUM(BN_C), .CFG_BASE(CB_C), .NEXT_CAP(NX_C)) cfg8_u (
        .CLOCK(clk), .SYS_RST(rst), .REQ_RD(rd_s), .REQ_WR(wr_s), .REQ_ADDR(addr),
        .REQ_WDATA(wdata), .RSP_VALID(vc), .RSP_RDATA(dc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t valid %b expected %b", $time, got, exp);
        end
    endtask

    // One read seen by all three banks; the idle cycle before it checks the pulse ended
    task automatic rd(input logic [11:0] a, input logic [31:0] ea, eb, ec);
        @(posedge clk);
        #1;
        chk_flag({va, vb, vc}, 3'h0);
        rd_s = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_s = 1'b0;
        chk_flag({va, vb, vc}, 3'h7);
        chk(da, ea);
        chk(db, eb);
        chk(dc, ec);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_s = 1'b0;
        chk_flag({va, vb, vc}, 3'h0);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        rd_s = 1'b0;
        wr_s = 1'b0;
        addr = 12'h000;
        wdata = 32'h0000_0000;
        error_cnt = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk_flag({va, vb, vc}, 3'h0);
        chk(da, 32'h0000_0000);
        $display("test reset done");
        rd(LO, A_LO, B_LO, C_LO);
        rd(HI, CB[63:32], MB[63:32], 32'h0000_0000);
        rd(LO + 12'h003, A_LO, B_LO, C_LO);
        rd(CAP, A_CAP, 32'h0000_0000, C_CAP);
        rd(12'h000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        rd(CAP + 12'h004, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        $display("test layouts done");
        wr(LO, 32'hFFFF_FFFF);
        wr(HI, 32'hFFFF_FFFF);
        wr(CAP, 32'h0000_0000);
        rd(LO, A_LO, B_LO, C_LO);
        rd(HI, CB[63:32], MB[63:32], 32'h0000_0000);
        rd(CAP, A_CAP, 32'h0000_0000, C_CAP);
        $display("test writes done");
        @(posedge clk);
        #1;
        rd_s = 1'b1;
        addr = HI;
        @(posedge clk);
        #1;
        addr = CAP;
        chk(da, CB[63:32]);
        @(posedge clk);
        #1;
        rd_s = 1'b0;
        chk_flag({va, vb, vc}, 3'h7);
        chk(da, A_CAP);
        $display("test back to back done");
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        chk(da, 32'h0000_0000);
        rd(LO, A_LO, B_LO, C_LO);
        $display("test second reset done");
        stop_test;
    end

    initial begin
        #20000;
        error_cnt++;
        stop_test;
    end
endmodule
